// ==== core/flag_bank.sv ====
// Sticky flag bank with load, clear-all and set-wins priority
`timescale 1ns/1ps

module flag_bank #(
  parameter int WIDTH = 7
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] setVec,
  input wire logic loadEn,
  input wire logic [WIDTH-1:0] loadVal,
  input wire logic clearAll,
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] next_flags;

  // ****************************************
  // Next value
  // ****************************************
  // Set is applied last, so an event in the clearing cycle survives
  always_comb begin
    next_flags = flags;
    if (loadEn) begin
      next_flags = loadVal;
    end
    if (clearAll) begin
      next_flags = '0;
    end
    next_flags = next_flags | setVec;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// ==== core/uart_interrupt_status_clear.sv ====
// Interrupt status and clear register of the serial bridge, with its access gate
`timescale 1ns/1ps
`include "uart_isc_regs.svh"

// Summary of operation
// - Register at 0x0F reachable only with line control 0xBF and special bit 2 set
// - Register reads zero after reset: all flags and clear bit low
// - Bit 7 shows the handshake line change interrupt
// - Bit 6 shows the Xoff or special character interrupt
// - Bit 5 shows the modem status interrupt
// - Bit 4 shows the transmit holding register interrupt
// - Bit 3 shows the receiver timeout interrupt
// - Bit 2 shows the receive holding register interrupt
// - Bit 1 shows the receive line error interrupt
// - Writing one to bit 0 clears every status flag whose source is not firing in that cycle
// - Clear bit never stays set; it always reads back zero
module uart_interrupt_status_clear
  import uart_isc_pkg::*;
#(
  parameter int FLAG_COUNT = 7
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire regReq_t regReq,
  input wire logic [7:0] lineControl,
  input wire logic [7:0] specialFunction,
  input wire irqSrc_t irqSrc,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic accessRefused,
  output irqSrc_t irqFlags,
  output logic irqActive
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic gateOpen(input logic [7:0] lineCtrl, input logic [7:0] specialFn);
    gateOpen = (lineCtrl == `ISC_GATE_LINE_CTRL) && specialFn[`SPECIAL_ACCESS_BIT];
  endfunction

  function automatic logic addrHit(input logic [3:0] addr);
    addrHit = (addr == `ISC_OFFSET);
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  // Async assert, release through two flops to avoid recovery hazards
  logic [1:0] rstPipe;
  logic rstSyncN;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe[1];

  // ****************************************
  // Access decode
  // ****************************************
  logic open;
  logic wrHit;
  logic rdHit;
  logic rdTaken;
  logic refuseNow;
  logic [FLAG_COUNT-1:0] srcVec;
  logic [FLAG_COUNT-1:0] flagVec;
  logic [FLAG_COUNT-1:0] wrFlags;
  logic clearCmd;

  assign open = gateOpen(lineControl, specialFunction);
  // A write in the same cycle takes precedence; the read is dropped
  assign rdTaken = regReq.rd && !regReq.wr && addrHit(regReq.addr);
  assign wrHit = regReq.wr && addrHit(regReq.addr) && open;
  assign rdHit = rdTaken && open;
  // Refused accesses leave the flags alone and raise a one-cycle marker; a refused read loads zero into the read data
  assign refuseNow = (regReq.wr || regReq.rd) && addrHit(regReq.addr) && !open;
  assign srcVec = irqSrc;
  assign wrFlags = regReq.data[`ISC_FLAG_MSB:`ISC_FLAG_LSB];
  // Clear command is a strobe only; nothing stores bit 0
  assign clearCmd = wrHit && regReq.data[`ISC_BIT_CLEAR];

  // ****************************************
  // Flag storage
  // ****************************************
  // Flags are writable so software can also clear single bits
  flag_bank #(
    .WIDTH(FLAG_COUNT)
  ) u_flags (
    .clk(clk_sys),
    .rstN(rstSyncN),
    .setVec(srcVec),
    .loadEn(wrHit),
    .loadVal(wrFlags),
    .clearAll(clearCmd),
    .flags(flagVec)
  );

  assign irqFlags = flagVec;

  // ****************************************
  // Read path
  // ****************************************
  // Data shows the flags as they stood in the request cycle
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rdData <= `ISC_RESET;
    end else if (rdHit) begin
      rdData <= {flagVec, 1'b0};
    end else if (rdTaken) begin
      rdData <= `ISC_READ_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdTaken;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      accessRefused <= 1'b0;
    end else begin
      accessRefused <= refuseNow;
    end
  end

  // ****************************************
  // Summary output
  // ****************************************
  // Follows the flags one cycle late, kept registered for clean timing
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irqActive <= 1'b0;
    end else begin
      irqActive <= |flagVec;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] regImage;
  assign regImage = {flagVec, 1'b0};

  a_gate_write_block: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (regReq.wr && addrHit(regReq.addr) && !open && (srcVec == '0))
      |=> (flagVec == $past(flagVec))
  ) else $error("Write passed a closed access gate");

  a_gate_read_zero: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (rdTaken && !open) |=> (rdValid && accessRefused && (rdData == `ISC_READ_IDLE))
  ) else $error("Closed gate read did not return zero");

  a_reset_clear: assert property (
    @(posedge clk_sys)
    $rose(rstSyncN) |-> ((regImage == `ISC_RESET) && !rdValid && !irqActive)
  ) else $error("Register not zero after reset");

  a_handshake_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    irqSrc.handshake |=> regImage[`ISC_BIT_HANDSHAKE]
  ) else $error("Handshake flag not set");

  a_xoff_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    irqSrc.xoffChar |=> regImage[`ISC_BIT_XOFF]
  ) else $error("Xoff flag not set");

  a_modem_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    irqSrc.modem |=> regImage[`ISC_BIT_MODEM]
  ) else $error("Modem flag not set");

  a_txhold_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    irqSrc.txHold |=> regImage[`ISC_BIT_TX_HOLD]
  ) else $error("Transmit holding flag not set");

  a_timeout_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    irqSrc.rxTimeout |=> regImage[`ISC_BIT_RX_TIMEOUT]
  ) else $error("Receiver timeout flag not set");

  a_rxhold_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    irqSrc.rxHold |=> regImage[`ISC_BIT_RX_HOLD]
  ) else $error("Receive holding flag not set");

  a_line_err_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    irqSrc.lineErr |=> regImage[`ISC_BIT_LINE_ERR]
  ) else $error("Line error flag not set");

  a_clear_all: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (clearCmd && (srcVec == '0)) |=> (flagVec == `ISC_FLAGS_RESET)
  ) else $error("Clear command left a flag set");

  a_clear_self: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (wrHit ##2 rdHit) |=> (rdValid && !rdData[`ISC_BIT_CLEAR])
  ) else $error("Clear bit read back as one");

  a_flag_hold: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    !wrHit |=> ((flagVec & $past(flagVec)) == $past(flagVec))
  ) else $error("Flag dropped without clear");

  a_read_image: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    rdHit |=> (rdValid && (rdData == {$past(flagVec), 1'b0}))
  ) else $error("Read data differ from flags");

  // ****************************************
  // Access, flag and reset checks
  // ****************************************

  a_refuse_pulse: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    refuseNow |=> accessRefused
  ) else $error("Closed gate access not marked");

  a_refuse_quiet: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    !refuseNow |=> !accessRefused
  ) else $error("Refusal marker without cause");

  a_open_read_valid: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    rdHit |=> (rdValid && !accessRefused)
  ) else $error("Open gate read not answered");

  a_other_offset: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    !addrHit(regReq.addr) |=> (!rdValid && !accessRefused)
  ) else $error("Other offset answered");

  a_other_write_hold: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (regReq.wr && !addrHit(regReq.addr) && (srcVec == '0)) |=> $stable(flagVec)
  ) else $error("Other offset write changed flags");

  a_write_load: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (wrHit && !regReq.data[`ISC_BIT_CLEAR] && (srcVec == '0)) |=> (flagVec == $past(wrFlags))
  ) else $error("Written flags not loaded");

  a_clear_masks_load: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    clearCmd |=> ((flagVec & ~$past(srcVec)) == '0)
  ) else $error("Clear left a flag without source");

  a_set_beats_clear: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (clearCmd && (srcVec != '0)) |=> ((flagVec & $past(srcVec)) == $past(srcVec))
  ) else $error("Source lost to clear");

  a_no_spurious_set: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    (!wrHit && (srcVec == '0)) |=> (flagVec == $past(flagVec))
  ) else $error("Flag changed with no cause");

  a_active_follow: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    1'b1 |=> (irqActive == (|$past(flagVec)))
  ) else $error("Summary output does not follow flags");

  a_no_read_pulse: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    !rdTaken |=> !rdValid
  ) else $error("Read answer without request");

  a_rddata_hold: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    !rdTaken |=> $stable(rdData)
  ) else $error("Read data changed without read");

  a_read_bit0_low: assert property (
    @(posedge clk_sys) disable iff (!rstSyncN)
    rdValid |-> !rdData[`ISC_BIT_CLEAR]
  ) else $error("Clear bit visible in read data");

  a_reset_outputs: assert property (
    @(posedge clk_sys)
    !rstSyncN |-> ((flagVec == `ISC_FLAGS_RESET) && !rdValid && !accessRefused && !irqActive
      && (rdData == `ISC_RESET))
  ) else $error("Outputs not cleared during reset");

  a_sync_release: assert property (
    @(posedge clk_sys)
    $rose(nrst) |-> (!rstSyncN ##1 !rstSyncN ##1 rstSyncN)
  ) else $error("Reset release not two cycles");

endmodule

// ==== core/uart_isc_pkg.sv ====
// Types shared by the interrupt status register, its source model and its testbench
package uart_isc_pkg;

  // ****************************************
  // Register access request from the host port
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] data;
  } regReq_t;

  // ****************************************
  // Interrupt sources, register bit order 7 down to 1
  // ****************************************
  typedef struct packed {
    logic handshake;
    logic xoffChar;
    logic modem;
    logic txHold;
    logic rxTimeout;
    logic rxHold;
    logic lineErr;
  } irqSrc_t;

endpackage

// ==== core/uart_isc_regs.svh ====
// Offsets, gate values, bit positions and reset value of the interrupt status register
`ifndef UART_ISC_REGS_SVH
`define UART_ISC_REGS_SVH

// ****************************************
// Register placement and gating
// ****************************************
`define ISC_OFFSET 4'hf
`define ISC_RESET 8'h00
`define ISC_FLAGS_RESET 7'h00
`define ISC_READ_IDLE 8'h00
`define ISC_GATE_LINE_CTRL 8'hbf
`define SPECIAL_ACCESS_BIT 2

// ****************************************
// Bit positions inside the register
// ****************************************
`define ISC_BIT_HANDSHAKE 7
`define ISC_BIT_XOFF 6
`define ISC_BIT_MODEM 5
`define ISC_BIT_TX_HOLD 4
`define ISC_BIT_RX_TIMEOUT 3
`define ISC_BIT_RX_HOLD 2
`define ISC_BIT_LINE_ERR 1
`define ISC_BIT_CLEAR 0
`define ISC_FLAG_MSB 7
`define ISC_FLAG_LSB 1

`endif

// ==== sim/irq_source_model.sv ====
// Behavioural model of the UART datapath that raises the interrupt sources
`timescale 1ns/1ps

module irq_source_model
  import uart_isc_pkg::*;
(
  input wire logic clk_sys,
  output irqSrc_t irqSrc
);
  // ****************************************
  // Source pulses
  // ****************************************
  initial irqSrc = '0;

  // One-cycle pulse, the shortest event a source gives
  task automatic pulse(input logic [6:0] v);
    @(negedge clk_sys);
    irqSrc = v;
    @(negedge clk_sys);
    irqSrc = '0;
  endtask
endmodule

// ==== sim/uart_interrupt_status_clear_tb.sv ====
// Self-checking testbench of the interrupt status and clear register
`timescale 1ns/1ps

module uart_interrupt_status_clear_tb;
  import uart_isc_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  regReq_t regReq = '0;
  logic [7:0] lineControl = 8'hbf;
  logic [7:0] specialFunction = 8'h04;
  irqSrc_t irqSrc;
  logic [7:0] rdData;
  logic rdValid;
  logic accessRefused;
  irqSrc_t irqFlags;
  logic irqActive;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;

  always #20 clk_sys = ~clk_sys;

  uart_interrupt_status_clear #(.FLAG_COUNT(7)) dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .regReq(regReq),
    .lineControl(lineControl),
    .specialFunction(specialFunction),
    .irqSrc(irqSrc),
    .rdData(rdData),
    .rdValid(rdValid),
    .accessRefused(accessRefused),
    .irqFlags(irqFlags),
    .irqActive(irqActive)
  );

  irq_source_model src (.clk_sys(clk_sys), .irqSrc(irqSrc));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle request, dropped at the next falling edge
  task automatic access(input logic wr, input logic rd, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regReq = '{wr: wr, rd: rd, addr: a, data: d};
    @(negedge clk_sys);
    regReq = '0;
  endtask

  // Answer stands one cycle, so it is sampled right after the take
  task automatic rd_chk(input string what, input logic [7:0] exp, input logic refused);
    access(1'b0, 1'b1, 4'hf, 8'h00);
    check({what, " valid"}, {7'h00, rdValid}, 8'h01);
    check({what, " refused"}, {7'h00, accessRefused}, {7'h00, refused});
    check(what, rdData, exp);
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs about 110 cycles; ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd_chk("reset value", 8'h00, 1'b0);
    for (int i = 0; i < 7; i++) begin
      src.pulse(7'h01 << i);
      rd_chk("source flag", 8'h02 << i, 1'b0);
      access(1'b1, 1'b0, 4'hf, 8'h01);
      rd_chk("cleared", 8'h00, 1'b0);
      check("idle active", {7'h00, irqActive}, 8'h00);
    end
    src.pulse(7'h41);
    repeat (5) @(negedge clk_sys);
    check("held flags", {irqFlags, 1'b0}, 8'h82);
    check("active", {7'h00, irqActive}, 8'h01);
    rd_chk("held read", 8'h82, 1'b0);
    rd_chk("reread", 8'h82, 1'b0);
    lineControl = 8'hbe;
    rd_chk("closed line", 8'h00, 1'b1);
    access(1'b1, 1'b0, 4'hf, 8'h01);
    check("refused write line", {7'h00, accessRefused}, 8'h01);
    lineControl = 8'hbf;
    specialFunction = 8'hfb;
    rd_chk("closed special", 8'h00, 1'b1);
    access(1'b1, 1'b0, 4'hf, 8'h01);
    check("refused write special", {7'h00, accessRefused}, 8'h01);
    specialFunction = 8'h04;
    access(1'b0, 1'b1, 4'he, 8'h00);
    check("other offset", {7'h00, rdValid}, 8'h00);
    check("other offset refused", {7'h00, accessRefused}, 8'h00);
    access(1'b1, 1'b0, 4'he, 8'h01);
    rd_chk("kept", 8'h82, 1'b0);
    access(1'b1, 1'b0, 4'hf, 8'haa);
    rd_chk("loaded", 8'haa, 1'b0);
    access(1'b1, 1'b0, 4'hf, 8'hff);
    rd_chk("load and clear", 8'h00, 1'b0);
    // Source and clear in one cycle: the source wins
    fork
      src.pulse(7'h10);
      access(1'b1, 1'b0, 4'hf, 8'h01);
    join
    rd_chk("set over clear", 8'h20, 1'b0);
    nrst = 1'b0;
    @(negedge clk_sys);
    check("flags in reset", {irqFlags, 1'b0}, 8'h00);
    check("read data in reset", rdData, 8'h00);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd_chk("after reset", 8'h00, 1'b0);
    end_sim();
  end
endmodule
